// ---- hbs_pkg.sv ----
`default_nettype none
package hbs_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int unsigned ADDR_W          = 8;
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_STATUS     = 8'h04;
  localparam logic [7:0]  ADDR_MASK       = 8'h08;
  localparam logic [7:0]  ADDR_BRK_TIMER  = 8'h0C;
  localparam logic [7:0]  ADDR_SYNC_TIMER = 8'h10;
  localparam logic [7:0]  ADDR_SYNC_CMP   = 8'h14;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int unsigned CTRL_W          = 13;
  localparam int unsigned STATUS_W        = 7;
  localparam int unsigned TMR_W           = 16;
  localparam logic [12:0] CTRL_RST        = 13'h0000;
  localparam logic [6:0]  STATUS_RST      = 7'h00;
  localparam logic [6:0]  MASK_RST        = 7'h00;
  localparam logic [15:0] CMP_RST         = 16'hFFFF;
  localparam int unsigned ST_BRK_RISE     = 0;
  localparam int unsigned ST_BRK_CMP      = 1;
  localparam int unsigned ST_BRK_OVF      = 2;
  localparam int unsigned ST_SYNC_CMP     = 3;

  // ****************************************
  // Timing counts
  // ****************************************
  localparam logic [15:0] BREAK_MIN_CYC   = 16'h0A28;
  localparam logic [2:0]  SYNC_FALLS      = 3'h5;

  // Layout of sync_control_first, msb first
  typedef struct packed {
    logic rise_cfg;
    logic brk_cmp_dis;
    logic brk_err_dis;
    logic xcvr_test;
    logic rx_gate;
    logic stop_edge;
    logic bsd_mode;
    logic cmp_ie;
    logic stop_ie;
    logic start_ie;
    logic sync_en;
    logic [1:0] rsvd;
  } hbs_ctrl_t;

  // Layout of sync_status_flags and its mask, msb first
  typedef struct packed {
    logic synced;
    logic stop;
    logic start;
    logic sync_cmp;
    logic brk_ovf;
    logic brk_cmp;
    logic brk_rise;
  } hbs_evt_t;

  typedef enum {HBS_HUNT, HBS_WAIT_SYNC, HBS_SYNC_BYTE, HBS_SYNCED} hbs_state_t;

endpackage : hbs_pkg
`default_nettype wire

// ---- hbs_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module hbs_timer #(
  parameter int unsigned W = 16
) (
  input  wire logic         pclk,     // Clock
  input  wire logic         presetn,  // Async reset, low
  input  wire logic         start,    // Clear and run
  input  wire logic         stop,     // Halt, value kept
  input  wire logic [W-1:0] cmp_val,  // Compare value
  output logic      [W-1:0] count,    // Current count
  output logic              running,  // Counting
  output logic              hit,      // Count equals compare
  output logic              ovf       // Wrap pulse
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running <= 1'b0;
    end else if (start) begin
      running <= 1'b1;
    end else if (stop) begin
      running <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (start) begin
      count <= '0;
    end else if (running && !stop) begin
      count <= count + {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign hit = running && !stop && (count == cmp_val);
  assign ovf = running && !stop && (count == {W{1'b1}});

endmodule : hbs_timer
`default_nettype wire

// ---- hbs_sync_control.sv ----
// Summary of operation
// - Error interrupt suppressed while its disable set
// - Compare interrupt allowed while its disable clear
// - Test bit clear: transceiver driven from UART
// - Test bit set: pins route transceiver, bypass UART
// - Gate set, pulse bus mode clear: UART receive high until sync
// - Gate clear, test bit clear: bus data reaches UART receive
// - Read mode gate set: rising edge flags
// - Break timer runs falling to rising edge
// - Break timer compare and overflow still interrupt
// - Write mode: compare match flags bit 3
// - Break timer stops on rising edge too
// - Sync timer compare match sets flag
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module hbs_sync_control #(
  parameter int unsigned     TW        = hbs_pkg::TMR_W,
  parameter logic [TW-1:0]   BREAK_MIN = hbs_pkg::BREAK_MIN_CYC,
  parameter logic [2:0]      NFALLS    = hbs_pkg::SYNC_FALLS
) (
  input  wire logic        pclk,         // Clock, 250 MHz
  input  wire logic        presetn,      // Async reset, low
  input  wire logic [7:0]  paddr,        // APB address
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB enable
  input  wire logic        pwrite,       // APB direction
  input  wire logic [31:0] pwdata,       // APB write data
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error
  output logic             irq,          // Interrupt, level
  input  wire logic        bus_rx_pin,   // Transceiver receive out
  output logic             xcvr_txd,     // Transceiver transmit in
  input  wire logic        uart_txd,     // UART transmit
  output logic             uart_rxd,     // UART receive
  input  wire logic        gpio_tx_pin,  // Test pin to transceiver
  output logic             gpio_rx_pin   // Test pin from transceiver
);

  // ****************************************
  // Registers and wires
  // ****************************************
  hbs_pkg::hbs_ctrl_t   ctrl_reg;
  hbs_pkg::hbs_evt_t    status_reg;
  hbs_pkg::hbs_evt_t    mask_reg;
  hbs_pkg::hbs_evt_t    ev;
  hbs_pkg::hbs_evt_t    rd_clr;
  hbs_pkg::hbs_state_t  state_reg;
  logic [TW-1:0]        brk_cmp_reg;
  logic [TW-1:0]        sync_cmp_reg;
  logic [31:0]          prdata_reg;
  logic                 pslverr_reg;
  logic                 stat_rd_reg;
  logic                 bus_meta_reg;
  logic                 bus_s_reg;
  logic                 bus_d_reg;
  logic                 gpio_meta_reg;
  logic                 gpio_s_reg;
  logic                 xcvr_txd_reg;
  logic                 uart_rxd_reg;
  logic                 gpio_rx_reg;
  logic [2:0]           falls_reg;
  logic                 rise;
  logic                 fall;
  logic                 active;
  logic                 lin_act;
  logic                 brk_long;
  logic                 sync_done;
  logic                 setup;
  logic                 access;
  logic                 wr_ok;
  logic [TW-1:0]        brk_count;
  logic                 brk_run;
  logic                 brk_hit;
  logic                 brk_ovf;
  logic [TW-1:0]        sync_count;
  logic                 sync_hit;
  logic                 sync_start;
  logic                 sync_stop;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == hbs_pkg::ADDR_CTRL)       || (a == hbs_pkg::ADDR_STATUS)   ||
               (a == hbs_pkg::ADDR_MASK)       || (a == hbs_pkg::ADDR_BRK_TIMER) ||
               (a == hbs_pkg::ADDR_SYNC_TIMER) || (a == hbs_pkg::ADDR_SYNC_CMP);
  endfunction : addr_hit

  function automatic logic [31:0] tmr_word(input logic [TW-1:0] v);
    tmr_word = {{(32-TW){1'b0}}, v};
  endfunction : tmr_word

  // ****************************************
  // Pin synchronisers and edges
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_meta_reg <= 1'b1;
      bus_s_reg    <= 1'b1;
      bus_d_reg    <= 1'b1;
    end else begin
      bus_meta_reg <= bus_rx_pin;
      bus_s_reg    <= bus_meta_reg;
      bus_d_reg    <= bus_s_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_meta_reg <= 1'b1;
      gpio_s_reg    <= 1'b1;
    end else begin
      gpio_meta_reg <= gpio_tx_pin;
      gpio_s_reg    <= gpio_meta_reg;
    end
  end

  assign rise    = bus_s_reg && !bus_d_reg;
  assign fall    = !bus_s_reg && bus_d_reg;
  assign active  = ctrl_reg.sync_en;
  assign lin_act = active && !ctrl_reg.bsd_mode;

  // ****************************************
  // Break and sync bit timers
  // ****************************************
  hbs_timer #(.W(TW)) u_brk_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (active && fall),
    .stop    (rise || !active),
    .cmp_val (brk_cmp_reg),
    .count   (brk_count),
    .running (brk_run),
    .hit     (brk_hit),
    .ovf     (brk_ovf)
  );

  assign sync_start = ctrl_reg.bsd_mode ? (active && fall) :
                      (lin_act && fall && (state_reg == hbs_pkg::HBS_WAIT_SYNC));
  assign sync_stop  = !active || (ctrl_reg.bsd_mode ? rise : sync_done);

  hbs_timer #(.W(TW)) u_sync_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (sync_start),
    .stop    (sync_stop),
    .cmp_val (sync_cmp_reg),
    .count   (sync_count),
    .running (),
    .hit     (sync_hit),
    .ovf     ()
  );

  // ****************************************
  // Break and sync byte detection
  // ****************************************
  assign brk_long  = lin_act && rise && (brk_count >= BREAK_MIN);
  assign sync_done = lin_act && rise && !brk_long && (falls_reg == NFALLS) &&
                     (state_reg == hbs_pkg::HBS_SYNC_BYTE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= hbs_pkg::HBS_HUNT;
      falls_reg <= 3'h0;
    end else if (!lin_act) begin
      state_reg <= hbs_pkg::HBS_HUNT;
      falls_reg <= 3'h0;
    end else if (brk_long) begin
      state_reg <= hbs_pkg::HBS_WAIT_SYNC;
      falls_reg <= 3'h0;
    end else begin
      case (state_reg)
        hbs_pkg::HBS_WAIT_SYNC: begin
          if (fall) begin
            state_reg <= hbs_pkg::HBS_SYNC_BYTE;
            falls_reg <= 3'h1;
          end
        end
        hbs_pkg::HBS_SYNC_BYTE: begin
          if (sync_done) begin
            state_reg <= hbs_pkg::HBS_SYNCED;
          end else if (fall && falls_reg != NFALLS) begin
            falls_reg <= falls_reg + 3'h1;
          end else if (fall) begin
            state_reg <= hbs_pkg::HBS_HUNT;
          end
        end
        hbs_pkg::HBS_HUNT,
        hbs_pkg::HBS_SYNCED: begin
          state_reg <= state_reg;
        end
        default: begin
          state_reg <= hbs_pkg::HBS_HUNT;
        end
      endcase
    end
  end

  // ****************************************
  // Transceiver and UART routing
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xcvr_txd_reg <= 1'b1;
      gpio_rx_reg  <= 1'b1;
      uart_rxd_reg <= 1'b1;
    end else begin
      xcvr_txd_reg <= ctrl_reg.xcvr_test ? gpio_s_reg : uart_txd;
      gpio_rx_reg  <= ctrl_reg.xcvr_test ? bus_s_reg : 1'b1;
      if (ctrl_reg.xcvr_test) begin
        uart_rxd_reg <= 1'b1;
      end else if (!ctrl_reg.bsd_mode && ctrl_reg.rx_gate &&
                   state_reg != hbs_pkg::HBS_SYNCED) begin
        uart_rxd_reg <= 1'b1;
      end else begin
        uart_rxd_reg <= bus_s_reg;
      end
    end
  end

  assign xcvr_txd    = xcvr_txd_reg;
  assign gpio_rx_pin = gpio_rx_reg;
  assign uart_rxd    = uart_rxd_reg;

  // ****************************************
  // Events
  // ****************************************
  always_comb begin
    ev          = '0;
    ev.brk_rise = active && rise && (ctrl_reg.bsd_mode ?
                  (ctrl_reg.rx_gate && !ctrl_reg.rise_cfg) : ctrl_reg.rise_cfg);
    ev.brk_cmp  = active && brk_hit && !ctrl_reg.brk_cmp_dis;
    ev.brk_ovf  = active && brk_ovf && !ctrl_reg.brk_err_dis;
    ev.sync_cmp = active && ctrl_reg.cmp_ie && sync_hit;
    ev.start    = active && ctrl_reg.start_ie && fall;
    ev.stop     = active && ctrl_reg.stop_ie && rise;
    ev.synced   = sync_done;
  end

  // ****************************************
  // APB slave
  // ****************************************
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wr_ok  = access && pwrite && addr_hit(paddr);
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = access && pslverr_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
      stat_rd_reg <= 1'b0;
    end else if (setup) begin
      pslverr_reg <= !addr_hit(paddr);
      stat_rd_reg <= !pwrite && (paddr == hbs_pkg::ADDR_STATUS);
      case (paddr)
        hbs_pkg::ADDR_CTRL:       prdata_reg <= {{(32-hbs_pkg::CTRL_W){1'b0}}, ctrl_reg};
        hbs_pkg::ADDR_STATUS:     prdata_reg <= {{(32-hbs_pkg::STATUS_W){1'b0}}, status_reg};
        hbs_pkg::ADDR_MASK:       prdata_reg <= {{(32-hbs_pkg::STATUS_W){1'b0}}, mask_reg};
        hbs_pkg::ADDR_BRK_TIMER:  prdata_reg <= tmr_word(brk_count);
        hbs_pkg::ADDR_SYNC_TIMER: prdata_reg <= tmr_word(sync_count);
        hbs_pkg::ADDR_SYNC_CMP:   prdata_reg <= tmr_word(sync_cmp_reg);
        default:                  prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= hbs_pkg::CTRL_RST;
    end else if (wr_ok && paddr == hbs_pkg::ADDR_CTRL) begin
      ctrl_reg      <= pwdata[hbs_pkg::CTRL_W-1:0];
      ctrl_reg.rsvd <= 2'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= hbs_pkg::MASK_RST;
    end else if (wr_ok && paddr == hbs_pkg::ADDR_MASK) begin
      mask_reg <= pwdata[hbs_pkg::STATUS_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_cmp_reg  <= hbs_pkg::CMP_RST[TW-1:0];
      sync_cmp_reg <= hbs_pkg::CMP_RST[TW-1:0];
    end else if (wr_ok && paddr == hbs_pkg::ADDR_BRK_TIMER) begin
      brk_cmp_reg  <= pwdata[TW-1:0];
    end else if (wr_ok && paddr == hbs_pkg::ADDR_SYNC_CMP) begin
      sync_cmp_reg <= pwdata[TW-1:0];
    end
  end

  // ****************************************
  // Sticky status, cleared by read
  // ****************************************
  // Only bits that were captured for the read are cleared
  assign rd_clr = (access && stat_rd_reg) ? prdata_reg[hbs_pkg::STATUS_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= hbs_pkg::STATUS_RST;
    end else begin
      status_reg <= (status_reg & ~rd_clr) | ev;
    end
  end

  assign irq = |(status_reg & mask_reg);

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_err_suppress: assert property ($rose(status_reg.brk_ovf) |->
    $past(ctrl_reg.sync_en && !ctrl_reg.brk_err_dis))
    else $error("overflow flag set while disabled");
  a_err_allow: assert property (active && brk_ovf && !ctrl_reg.brk_err_dis
    |=> status_reg.brk_ovf)
    else $error("overflow flag missing");
  a_cmp_suppress: assert property ($rose(status_reg.brk_cmp) |->
    $past(ctrl_reg.sync_en && !ctrl_reg.brk_cmp_dis))
    else $error("break compare flag set while disabled");
  a_cmp_allow: assert property (active && brk_hit && !ctrl_reg.brk_cmp_dis
    |=> status_reg.brk_cmp)
    else $error("break compare flag missing");
  a_txd_normal: assert property ($past(!ctrl_reg.xcvr_test) |->
    xcvr_txd == $past(uart_txd))
    else $error("transceiver not driven from uart");
  a_txd_test: assert property ($past(ctrl_reg.xcvr_test) |->
    (xcvr_txd == $past(gpio_s_reg)) && (gpio_rx_pin == $past(bus_s_reg)) && uart_rxd)
    else $error("test routing wrong");
  a_rx_gated: assert property (!ctrl_reg.xcvr_test && !ctrl_reg.bsd_mode
    && ctrl_reg.rx_gate && state_reg != hbs_pkg::HBS_SYNCED |=> uart_rxd)
    else $error("uart receive not gated");
  a_rx_open: assert property (!ctrl_reg.xcvr_test && !ctrl_reg.rx_gate
    |=> uart_rxd == $past(bus_s_reg))
    else $error("uart receive not passed");
  a_rise_flag: assert property (active && ctrl_reg.bsd_mode && ctrl_reg.rx_gate
    && !ctrl_reg.rise_cfg && rise |=> status_reg.brk_rise)
    else $error("rising edge flag missing");
  a_brk_start: assert property (active && fall |=> brk_run && brk_count == '0 ##1
    (brk_count == 1 || !brk_run))
    else $error("break timer did not start");
  a_brk_stop: assert property (rise && !fall |=> !brk_run
    ##1 ($stable(brk_count) || fall))
    else $error("break timer did not stop");
  a_sync_cmp: assert property (active && ctrl_reg.cmp_ie && sync_hit
    |=> status_reg.sync_cmp && (irq || !mask_reg.sync_cmp))
    else $error("sync compare flag missing");

endmodule : hbs_sync_control
`default_nettype wire

// ---- hbs_bus_node.sv ----
`timescale 1ns/1ps
`default_nettype none
module hbs_bus_node (
  input  wire logic pclk,        // Clock
  input  wire logic xcvr_txd,    // Device transmit level
  output logic      bus_rx_pin   // Bus level back to device
);
  // ****************************************
  // Wired bus, dominant low
  // ****************************************
  logic node_drv;  // Low pulls the bus down

  initial node_drv = 1'b1;

  // Pull-up when both parties release
  assign bus_rx_pin = node_drv & xcvr_txd;

  task automatic set_level(input logic v);
    @(posedge pclk);
    node_drv <= v;
  endtask : set_level

  // Low pulse, then idle
  task automatic pulse(input int lo, input int hi);
    set_level(1'b0);
    repeat (lo) @(posedge pclk);
    node_drv <= 1'b1;
    repeat (hi) @(posedge pclk);
  endtask : pulse
endmodule : hbs_bus_node
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] exp;
    logic        err;
  } hbs_row_t;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, v, v2;
  logic        bus_rx_pin, xcvr_txd, uart_txd, uart_rxd, gpio_tx_pin, gpio_rx_pin, e;
  int          errors, comparisons;
  hbs_row_t    rows[10];

  hbs_sync_control #(.TW(8), .BREAK_MIN(8'h14)) hbs_sync_control_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .bus_rx_pin(bus_rx_pin), .xcvr_txd(xcvr_txd),
    .uart_txd(uart_txd), .uart_rxd(uart_rxd), .gpio_tx_pin(gpio_tx_pin),
    .gpio_rx_pin(gpio_rx_pin));

  hbs_bus_node hbs_bus_node_i (.pclk(pclk), .xcvr_txd(xcvr_txd), .bus_rx_pin(bus_rx_pin));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic report_and_stop();
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      errors++;
      report_and_stop();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, v2, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0000_0000, r, e);
  endtask : rd

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    errors = 0;
    comparisons = 0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    uart_txd = 1'b1;
    gpio_tx_pin = 1'b1;
    rows = '{'{0, hbs_pkg::ADDR_CTRL, 0, 32'h0000_0000, 0},
             '{0, hbs_pkg::ADDR_STATUS, 0, 32'h0000_0000, 0},
             '{0, hbs_pkg::ADDR_MASK, 0, 32'h0000_0000, 0},
             '{0, hbs_pkg::ADDR_SYNC_CMP, 0, {24'h00_0000, hbs_pkg::CMP_RST[7:0]}, 0},
             '{1, hbs_pkg::ADDR_STATUS, 32'h0000_007F, 0, 0},
             '{0, hbs_pkg::ADDR_STATUS, 0, 32'h0000_0000, 0},
             '{0, 8'h18, 0, 32'h0000_0000, 1},
             '{1, 8'h1C, 32'h0000_0001, 0, 1},
             '{1, hbs_pkg::ADDR_SYNC_CMP, 32'h0000_0006, 0, 0},
             '{1, hbs_pkg::ADDR_MASK, 32'h0000_0001, 0, 0}};
    cyc(3);
    chk("reset outputs", {irq, xcvr_txd, uart_rxd, gpio_rx_pin}, 32'h0000_0007);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d, v, e);
      chk("apb error", e, rows[i].err);
      if (!rows[i].wr) chk("read data", v, rows[i].exp);
    end
    rd(hbs_pkg::ADDR_MASK, v);
    chk("mask readback", v, 32'h0000_0001);
    rd(hbs_pkg::ADDR_SYNC_CMP, v);
    chk("sync compare readback", v, 32'h0000_0006);
    // Normal routing: UART drives transceiver, bus reaches UART
    @(posedge pclk) uart_txd <= 1'b0;
    cyc(4);
    chk("xcvr_txd from uart", xcvr_txd, 1'b0);
    @(posedge pclk) uart_txd <= 1'b1;
    wr(hbs_pkg::ADDR_CTRL, 32'h0000_0004);
    hbs_bus_node_i.set_level(1'b0);
    cyc(8);
    chk("uart_rxd ungated", uart_rxd, 1'b0);
    hbs_bus_node_i.set_level(1'b1);
    // Pin functions assumed set before test mode
    wr(hbs_pkg::ADDR_CTRL, 32'h0000_0200);
    @(posedge pclk) gpio_tx_pin <= 1'b0;
    cyc(8);
    chk("xcvr_txd from pin", xcvr_txd, 1'b0);
    chk("gpio_rx_pin bus", gpio_rx_pin, 1'b0);
    chk("uart_rxd bypassed", uart_rxd, 1'b1);
    @(posedge pclk) gpio_tx_pin <= 1'b1;
    @(posedge pclk) uart_txd <= 1'b0;
    cyc(8);
    chk("uart ignored", {xcvr_txd, gpio_rx_pin}, 32'h0000_0003);
    @(posedge pclk) uart_txd <= 1'b1;
    // Gated receive: break, then five falls of sync
    wr(hbs_pkg::ADDR_CTRL, 32'h0000_0104);
    rd(hbs_pkg::ADDR_STATUS, v);
    hbs_bus_node_i.set_level(1'b0);
    cyc(30);
    chk("uart_rxd in break", uart_rxd, 1'b1);
    hbs_bus_node_i.set_level(1'b1);
    cyc(10);
    for (int i = 0; i < 5; i++) begin
      hbs_bus_node_i.set_level(1'b0);
      cyc(6);
      chk("uart_rxd in sync", uart_rxd, 1'b1);
      hbs_bus_node_i.pulse(1, 8);
    end
    rd(hbs_pkg::ADDR_STATUS, v);
    chk("synced flag", v & 32'h0000_0040, 32'h0000_0040);
    hbs_bus_node_i.set_level(1'b0);
    cyc(8);
    chk("uart_rxd after sync", uart_rxd, 1'b0);
    hbs_bus_node_i.set_level(1'b1);
    cyc(10);
    // Pulse bus read mode, bus idle before switching
    wr(hbs_pkg::ADDR_CTRL, 32'h0000_0144);
    wr(hbs_pkg::ADDR_BRK_TIMER, 32'h0000_0005);
    rd(hbs_pkg::ADDR_STATUS, v);
    hbs_bus_node_i.pulse(10, 10);
    chk("irq on rise", irq, 1'b1);
    rd(hbs_pkg::ADDR_STATUS, v);
    chk("rise and compare", v & 32'h0000_0007, 32'h0000_0003);
    cyc(1);
    chk("irq cleared", irq, 1'b0);
    rd(hbs_pkg::ADDR_BRK_TIMER, v);
    chk("pulse width", (v >= 8 && v <= 12), 1'b1);
    rd(hbs_pkg::ADDR_STATUS, v);
    chk("read clears", v & 32'h0000_0007, 32'h0000_0000);
    wr(hbs_pkg::ADDR_CTRL, 32'h0000_0944);
    hbs_bus_node_i.pulse(10, 10);
    rd(hbs_pkg::ADDR_STATUS, v);
    chk("compare disabled", v & 32'h0000_0007, 32'h0000_0001);
    wr(hbs_pkg::ADDR_CTRL, 32'h0000_0144);
    hbs_bus_node_i.pulse(300, 10);
    rd(hbs_pkg::ADDR_STATUS, v);
    chk("overflow flagged", v & 32'h0000_0007, 32'h0000_0007);
    wr(hbs_pkg::ADDR_CTRL, 32'h0000_0544);
    hbs_bus_node_i.pulse(300, 10);
    rd(hbs_pkg::ADDR_STATUS, v);
    chk("overflow disabled", v & 32'h0000_0007, 32'h0000_0003);
    // Start and stop flags, rise flag switched off
    wr(hbs_pkg::ADDR_CTRL, 32'h0000_115C);
    hbs_bus_node_i.pulse(10, 10);
    rd(hbs_pkg::ADDR_STATUS, v);
    chk("start stop flags", v & 32'h0000_0037, 32'h0000_0032);
    // Pulse bus write mode, gate cleared
    wr(hbs_pkg::ADDR_CTRL, 32'h0000_0064);
    rd(hbs_pkg::ADDR_STATUS, v);
    @(posedge pclk) uart_txd <= 1'b0;
    cyc(30);
    @(posedge pclk) uart_txd <= 1'b1;
    cyc(10);
    rd(hbs_pkg::ADDR_STATUS, v);
    chk("sync compare only", v & 32'h0000_0009, 32'h0000_0008);
    rd(hbs_pkg::ADDR_BRK_TIMER, v);
    cyc(10);
    rd(hbs_pkg::ADDR_BRK_TIMER, v2);
    chk("timer stopped", v2, v);
    chk("timer ran", (v >= 20), 1'b1);
    // Reset in mid-run
    @(posedge pclk) presetn <= 1'b0;
    cyc(3);
    chk("mid reset outputs", {irq, xcvr_txd, uart_rxd, gpio_rx_pin}, 32'h0000_0007);
    presetn <= 1'b1;
    rd(hbs_pkg::ADDR_CTRL, v);
    chk("ctrl after reset", v, {19'h0_0000, hbs_pkg::CTRL_RST});
    rd(hbs_pkg::ADDR_MASK, v);
    chk("mask after reset", v, {25'h000_0000, hbs_pkg::MASK_RST});
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
